// ### rtl/rvd_consts.svh
// Register offsets, field positions, reset values and timing counts of the regulator control block.
`ifndef RVD_CONSTS_SVH
`define RVD_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define RVD_OFF_REGULATOR_CONTROL 4'h0
`define RVD_OFF_INT_STATUS        4'h1
`define RVD_OFF_INT_MASK          4'h2
`define RVD_OFF_EVENT_CONTROL     4'h3

// ****************************************************************
// Field positions of regulator_control
// ****************************************************************
`define RVD_BIT_REGULATOR_DISABLE 7
`define RVD_BIT_BUS_POWER_STATUS  6
`define RVD_BIT_MATCH_POLARITY    5
`define RVD_BIT_LOW_POWER_SELECT  4

// ****************************************************************
// Field positions of the event registers
// ****************************************************************
`define RVD_BIT_EVT_RISE          0
`define RVD_BIT_EVT_FALL          1
`define RVD_BIT_EVT_MATCH         2
`define RVD_BIT_CTL_INT_ENABLE    0
`define RVD_BIT_CTL_RESET_SOURCE  1

// ****************************************************************
// Reset values and the reserved-bit read value
// ****************************************************************
`define RVD_RESET_REGULATOR_CONTROL 8'h00
`define RVD_RESET_EVENT             3'h0
`define RVD_RESET_EVENT_CONTROL     2'h0
`define RVD_RESERVED_READ           4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define RVD_SYNC_STAGES 2

`endif

// ### rtl/rvd_pkg.sv
// Types shared by the regulator control block.
package rvd_pkg;

    // Selected operating mode of the core regulator.
    typedef enum logic {
        RVD_MODE_NORMAL    = 1'b0,
        RVD_MODE_LOW_POWER = 1'b1
    } rvd_mode_e;

    // Width of register data on the register port.
    typedef logic [7:0] rvd_data_t;

endpackage

// ### rtl/rvd_sync.sv
// Two-flop synchroniser for a single asynchronous level.
`timescale 1ns/1ps
`include "rvd_consts.svh"

module rvd_sync (
    // Clock and reset.
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    // Asynchronous level in, synchronised level out.
    input  wire logic async_in,
    output logic      sync_out
);

    // ****************************************************************
    // Synchroniser chain
    // ****************************************************************

    // First stage; only the second stage reads it, to contain metastability.
    logic meta_ff;
    // Second stage, safe for any logic to read.
    logic sync_ff;

    // Both stages clear to zero, so the bus reads as absent during reset.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// ### rtl/rvd_regulator_control.sv
// Register bank controlling the core regulator and sensing bus power.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "rvd_consts.svh"

// Operation
// [R1] Control register resets to all zeros.
// [R2] Bit 7 drives regulator disable control.
// [R3] Bit 6 reads synchronised bus power level.
// [R4] Interrupt asserts when level equals polarity.
// [R5] Interrupt is level, no pending flag.
// [R6] Reset request on match when enabled.
// [R7] Bit 4 selects low power mode.
// [R8] Reserved bits read zero, written zero.
// [R9] Software avoids disabling with high input.
// [R10] Status bit read-only and synchronised first.
module rvd_regulator_control (
    // Clock and reset.
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    // Register port.
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Bus power sense pin, asynchronous.
    input  wire logic       bus_power_in,
    // Regulator controls.
    output logic            regulator_disable_out,
    output logic            regulator_low_power_select_out,
    // Bus power match request and reset request.
    output logic            bus_power_irq_out,
    output logic            bus_power_reset_out,
    // Sticky event interrupt.
    output logic            event_irq_out
);

    // ****************************************************************
    // Declarations
    // ****************************************************************

    // Regulator control storage; bit 6 and bits 3..0 are not stored.
    logic              regulator_disable_ff;
    logic              match_polarity_ff;
    rvd_pkg::rvd_mode_e mode_ff;
    // Event control: enable of match request and reset source select.
    logic [1:0]        event_control_ff;
    // Sticky event status and its mask.
    logic [2:0]        int_status_ff;
    logic [2:0]        int_mask_ff;
    logic [2:0]        nxt_int_status;
    // Synchronised bus power level and its previous value.
    logic              bus_power_sync;
    logic              bus_power_prev_ff;
    // Match between level and polarity.
    logic              level_match;
    // Decoded write strobes.
    logic              wr_ctrl;
    logic              wr_status;
    logic              wr_mask;
    logic              wr_evctl;
    // Read data register.
    logic [7:0]        rdata_ff;
    logic [7:0]        nxt_rdata;
    // Events seen this cycle.
    logic [2:0]        event_set;

    // ****************************************************************
    // Bus power synchroniser
    // ****************************************************************

    // The pin is not related to the clock, so it passes two flops first.
    rvd_sync u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (bus_power_in),
        .sync_out   (bus_power_sync)  // R10
    );

    // Previous level, for edge events.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bus_power_prev_ff <= 1'b0;
        end else begin
            bus_power_prev_ff <= bus_power_sync;
        end
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Each strobe is qualified by its own offset; unmapped writes are dropped.
    assign wr_ctrl   = wr_in && (addr_in == `RVD_OFF_REGULATOR_CONTROL);
    assign wr_status = wr_in && (addr_in == `RVD_OFF_INT_STATUS);
    assign wr_mask   = wr_in && (addr_in == `RVD_OFF_INT_MASK);
    assign wr_evctl  = wr_in && (addr_in == `RVD_OFF_EVENT_CONTROL);

    // ****************************************************************
    // Regulator control register
    // ****************************************************************

    // Writable fields; the status bit and reserved bits are never stored.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            regulator_disable_ff <= 1'b0;                  // [R1]
            match_polarity_ff    <= 1'b0;                  // [R1]
            mode_ff              <= rvd_pkg::RVD_MODE_NORMAL; // [R1]
        end else if (wr_ctrl) begin
            regulator_disable_ff <= wdata_in[`RVD_BIT_REGULATOR_DISABLE]; // [R2]
            match_polarity_ff    <= wdata_in[`RVD_BIT_MATCH_POLARITY];    // [R4]
            mode_ff              <= rvd_pkg::rvd_mode_e'(wdata_in[`RVD_BIT_LOW_POWER_SELECT]); // [R7]
        end
    end

    // The disable control is passed straight out; software must keep the
    // input voltage rule itself, hardware cannot sense the analog levels.
    assign regulator_disable_out          = regulator_disable_ff; // [R2]
    assign regulator_low_power_select_out = (mode_ff == rvd_pkg::RVD_MODE_LOW_POWER); // [R7]

    // ****************************************************************
    // Match request and reset request
    // ****************************************************************

    // Pure level compare with no storage, so it follows the line directly.
    assign level_match = (bus_power_sync == match_polarity_ff); // [R4] [R5]

    // Event control register: match request enable and reset source select.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            event_control_ff <= `RVD_RESET_EVENT_CONTROL;
        end else if (wr_evctl) begin
            event_control_ff <= wdata_in[1:0];
        end
    end

    // The request follows the level; there is nothing to clear.
    assign bus_power_irq_out =
        level_match && event_control_ff[`RVD_BIT_CTL_INT_ENABLE]; // [R4] [R5]
    // Reset request while enabled as a reset source and matching.
    assign bus_power_reset_out =
        level_match && event_control_ff[`RVD_BIT_CTL_RESET_SOURCE]; // [R6]

    // ****************************************************************
    // Sticky events
    // ****************************************************************

    // Rising edge, falling edge, and entry into a match.
    always_comb begin
        event_set = `RVD_RESET_EVENT;
        event_set[`RVD_BIT_EVT_RISE]  = bus_power_sync && !bus_power_prev_ff;
        event_set[`RVD_BIT_EVT_FALL]  = !bus_power_sync && bus_power_prev_ff;
        event_set[`RVD_BIT_EVT_MATCH] = (bus_power_sync != bus_power_prev_ff) && level_match;
    end

    // Write one to clear; a new event in the same cycle wins over the clear.
    always_comb begin
        nxt_int_status = int_status_ff;
        if (wr_status) begin
            nxt_int_status = int_status_ff & ~wdata_in[2:0];
        end
        nxt_int_status = nxt_int_status | event_set;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_status_ff <= `RVD_RESET_EVENT;
        end else begin
            int_status_ff <= nxt_int_status;
        end
    end

    // Mask register; a one lets the matching status bit through.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_mask_ff <= `RVD_RESET_EVENT;
        end else if (wr_mask) begin
            int_mask_ff <= wdata_in[2:0];
        end
    end

    assign event_irq_out = |(int_status_ff & int_mask_ff);

    // ****************************************************************
    // Read path
    // ****************************************************************

    // Read data select; unmapped offsets answer zero.
    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_in) begin
            unique case (addr_in)
                `RVD_OFF_REGULATOR_CONTROL: begin
                    nxt_rdata = {regulator_disable_ff,
                                 bus_power_sync,                   // [R3] [R10]
                                 match_polarity_ff,
                                 regulator_low_power_select_out,
                                 `RVD_RESERVED_READ};              // [R8]
                end
                `RVD_OFF_INT_STATUS: begin
                    nxt_rdata = {5'h00, int_status_ff};
                end
                `RVD_OFF_INT_MASK: begin
                    nxt_rdata = {5'h00, int_mask_ff};
                end
                `RVD_OFF_EVENT_CONTROL: begin
                    nxt_rdata = {6'h00, event_control_ff};
                end
                default: begin
                    nxt_rdata = 8'h00;
                end
            endcase
        end
    end

    // Data stand only in the cycle after the read strobe, zero otherwise.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_out = rdata_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    AST_DISABLE_FOLLOWS_WRITE: assert property ( // R2
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        wr_ctrl |=> (regulator_disable_out == $past(wdata_in[7])))
        else $error("Regulator disable did not follow the write.");

    AST_STATUS_READ_LEVEL: assert property ( // R3
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == `RVD_OFF_REGULATOR_CONTROL)
        |=> (rdata_out[6] == $past(bus_power_sync)))
        else $error("Status bit does not show the bus power level.");

    AST_IRQ_ON_MATCH: assert property ( // R4
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        bus_power_irq_out == (event_control_ff[0]
                              && bus_power_sync == match_polarity_ff))
        else $error("Match request does not reflect level and polarity.");

    AST_IRQ_DROPS_ON_MISMATCH: assert property ( // R5
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        ($changed(bus_power_sync) && !level_match) |-> !bus_power_irq_out)
        else $error("Match request stayed high after mismatch.");

    AST_RESET_REQUEST: assert property ( // R6
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (event_control_ff[1] && level_match) |-> bus_power_reset_out)
        else $error("Reset request missing on match.");

    AST_LOW_POWER_WRITE: assert property ( // R7
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        wr_ctrl |=> (regulator_low_power_select_out == $past(wdata_in[4])))
        else $error("Low power select did not follow the write.");

    AST_RESERVED_ZERO: assert property ( // R8
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == `RVD_OFF_REGULATOR_CONTROL) |=> (rdata_out[3:0] == 4'h0))
        else $error("Reserved bits did not read zero.");

    AST_SYNC_LATENCY: assert property ( // R10
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(bus_power_in) ##1 bus_power_in[*2] |-> bus_power_sync)
        else $error("Status not synchronised in two cycles.");

    AST_RESET_ZERO: assert property ( // R1
        @(posedge ref_clk_in) $rose(rst_n_in)
        |-> (!regulator_disable_out && !regulator_low_power_select_out))
        else $error("Control register not zero after reset.");

    COV_IRQ: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(bus_power_irq_out));
    COV_RESET_REQ: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(bus_power_reset_out));
    COV_CLEAR_RACE: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        wr_status && |event_set);

endmodule

// ### verification/rvd_bus_power_model.sv
// Behavioural model of the bus power sense line that feeds the regulator block.
`timescale 1ns/1ps

// ****************************************************************
// Bus power source model
// ****************************************************************
module rvd_bus_power_model (
    // Commanded attach state and settling speed.
    input  wire logic level_in,
    input  wire logic slow_in,
    // Sense line seen by the device pin.
    output logic      bus_power_out
);
    // The line starts detached, as a device that is not plugged in.
    initial begin
        bus_power_out = 1'b0;
    end

    // The line moves off the clock edge on purpose: a cable attach is
    // asynchronous, so the design must synchronise it before use.
    // The slow setting mimics a sluggish cable edge near two cycles long.
    always @(level_in) begin
        if (slow_in) begin
            bus_power_out <= #13 level_in;
        end else begin
            bus_power_out <= #3 level_in;
        end
    end
endmodule

// ### verification/regulator_control_vbus_detect_tb.sv
// Self-checking testbench of the regulator control and bus power sense block.
`timescale 1ns/1ps
`include "rvd_consts.svh"

module regulator_control_vbus_detect_tb;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic       ref_clk   = 1'b0; // System clock, 125 MHz.
    logic       rst_n     = 1'b0; // Reset, active low.
    logic [3:0] addr      = 4'h0; // Register address.
    logic [7:0] wdata     = 8'h00; // Register write data.
    logic       wr        = 1'b0; // Write strobe.
    logic       rd        = 1'b0; // Read strobe.
    logic [7:0] rdata;            // Register read data.
    logic       pin_cmd   = 1'b0; // Commanded bus power state.
    logic       pin_slow  = 1'b0; // Slow edge selection for the model.
    logic       bus_power;        // Sense line into the design.
    logic       dis;              // Regulator disable control.
    logic       lp;               // Low power mode control.
    logic       irq;              // Bus power match request.
    logic       rst_req;          // Bus power reset request.
    logic       evt_irq;          // Sticky event interrupt.
    int         err_count = 0;    // Mismatches seen.
    int         tests_run = 0;    // Comparisons made.
    int         cycles    = 0;    // Cycles since time zero.

    // ****************************************************************
    // Instances
    // ****************************************************************
    rvd_bus_power_model u_src (
        .level_in      (pin_cmd),
        .slow_in       (pin_slow),
        .bus_power_out (bus_power)
    );

    rvd_regulator_control dut (
        .ref_clk_in                     (ref_clk),
        .rst_n_in                       (rst_n),
        .addr_in                        (addr),
        .wdata_in                       (wdata),
        .wr_in                          (wr),
        .rd_in                          (rd),
        .rdata_out                      (rdata),
        .bus_power_in                   (bus_power),
        .regulator_disable_out          (dis),
        .regulator_low_power_select_out (lp),
        .bus_power_irq_out              (irq),
        .bus_power_reset_out            (rst_req),
        .event_irq_out                  (evt_irq)
    );

    // Clock toggles every half period of 4 ns.
    always #4 ref_clk = ~ref_clk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe; the gap after it keeps each strobe a clean pulse.
    // Returns just past the taking edge, so a caller never races the update.
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample it there.
    task automatic reg_read(input logic [3:0] a, input string what, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1;
        check(what, rdata, exp);
    endtask

    // Moves the sense line and waits past the two synchroniser stages.
    task automatic set_pin(input logic v);
        pin_cmd = v;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask

    // Checks both match outputs together against their expected levels.
    task automatic check_match(input logic exp_irq, input logic exp_rst);
        check("match_irq", {7'h00, irq}, {7'h00, exp_irq});
        check("match_reset", {7'h00, rst_req}, {7'h00, exp_rst});
    endtask

    // ****************************************************************
    // Hang guard
    // ****************************************************************
    // The sequence needs well under 1000 cycles; 4000 means something hung.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            complete_run();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset values, sense line detached.
        reg_read(`RVD_OFF_REGULATOR_CONTROL, "ctrl_reset", 8'h00);
        check("disable_reset", {7'h00, dis}, 8'h00);
        check("low_power_reset", {7'h00, lp}, 8'h00);
        reg_read(`RVD_OFF_EVENT_CONTROL, "evctl_reset", 8'h00);
        // Disable and mode bits reach their controls; written in a self-powered setup only.
        reg_write(`RVD_OFF_REGULATOR_CONTROL, 8'h80);
        reg_read(`RVD_OFF_REGULATOR_CONTROL, "ctrl_disable", 8'h80);
        check("disable_set", {7'h00, dis}, 8'h01);
        reg_write(`RVD_OFF_REGULATOR_CONTROL, 8'h10);
        check("disable_clear", {7'h00, dis}, 8'h00);
        check("low_power_set", {7'h00, lp}, 8'h01);
        // The status bit refuses a written one; reserved bits are written zero.
        reg_write(`RVD_OFF_REGULATOR_CONTROL, 8'h40);
        reg_read(`RVD_OFF_REGULATOR_CONTROL, "ctrl_reserved", 8'h00);
        check("low_power_clear", {7'h00, lp}, 8'h00);
        // Unmapped address neither stores nor returns data.
        reg_write(4'h5, 8'hFF);
        reg_read(4'h5, "unmapped", 8'h00);
        // Every polarity against every level with both requests enabled.
        reg_write(`RVD_OFF_EVENT_CONTROL, 8'h03);
        for (int p = 0; p < 2; p++) begin
            reg_write(`RVD_OFF_REGULATOR_CONTROL, {2'b00, p[0], 5'h00});
            for (int v = 0; v < 2; v++) begin
                pin_slow = p[0];
                set_pin(v[0]);
                check_match(p[0] == v[0], p[0] == v[0]);
                reg_read(`RVD_OFF_REGULATOR_CONTROL, "ctrl_level", {1'b0, v[0], p[0], 5'h00});
            end
        end
        // Each enable gates only its own request; the line stays matched.
        set_pin(1'b1);
        for (int e = 0; e < 4; e++) begin
            reg_write(`RVD_OFF_EVENT_CONTROL, e[7:0]);
            check_match(e[0], e[1]);
        end
        // Sticky events: clear, then a rise into match and a fall.
        set_pin(1'b0);
        reg_write(`RVD_OFF_INT_MASK, 8'h07);
        reg_write(`RVD_OFF_INT_STATUS, 8'h07);
        check("event_irq_idle", {7'h00, evt_irq}, 8'h00);
        set_pin(1'b1);
        reg_read(`RVD_OFF_INT_STATUS, "status_rise", 8'h05);
        check("event_irq_set", {7'h00, evt_irq}, 8'h01);
        set_pin(1'b0);
        reg_read(`RVD_OFF_INT_STATUS, "status_fall", 8'h07);
        reg_write(`RVD_OFF_INT_STATUS, 8'h01);
        reg_read(`RVD_OFF_INT_STATUS, "status_w1c", 8'h06);
        reg_write(`RVD_OFF_INT_MASK, 8'h01);
        reg_read(`RVD_OFF_INT_MASK, "mask_readback", 8'h01);
        check("event_irq_masked", {7'h00, evt_irq}, 8'h00);
        reg_write(`RVD_OFF_INT_MASK, 8'h02);
        check("event_irq_unmasked", {7'h00, evt_irq}, 8'h01);
        reg_write(`RVD_OFF_INT_STATUS, 8'h07);
        check("event_irq_cleared", {7'h00, evt_irq}, 8'h00);
        // A second reset in mid-run returns every stored field to zero.
        reg_write(`RVD_OFF_REGULATOR_CONTROL, 8'hB0);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("disable_rerst", {7'h00, dis}, 8'h00);
        check("low_power_rerst", {7'h00, lp}, 8'h00);
        // Release on a rising edge, as the register port inputs are driven.
        @(posedge ref_clk);
        rst_n <= 1'b1;
        reg_read(`RVD_OFF_REGULATOR_CONTROL, "ctrl_rerst", 8'h00);
        check_match(1'b0, 1'b0);
        complete_run();
    end
endmodule
